// [include/rts_pkg.sv]
// Register map, field layout and timing constants for the strength and test register group.
package rts_pkg;

	// Register offsets, also used as byte addresses on the register port.
	localparam logic [7:0] RTS_SIG_STRENGTH_ADDR = 8'h0f;
	localparam logic [7:0] RTS_PIN_TEST_ADDR     = 8'h1a;
	localparam logic [7:0] RTS_DEC_TEST_ADDR     = 8'h1b;
	localparam logic [7:0] RTS_QUEUE_STATUS_ADDR = 8'h1c;

	// Reset values of the two writable test registers.
	localparam logic [7:0] RTS_PIN_TEST_RST = 8'h00;
	localparam logic [7:0] RTS_DEC_TEST_RST = 8'h00;

	// Field positions of the signal strength register.
	localparam int RTS_MAIN_LSB = 0;
	localparam int RTS_MAIN_MSB = 2;
	localparam int RTS_AUX_LSB  = 3;
	localparam int RTS_AUX_MSB  = 5;
	localparam int RTS_OSC_BIT  = 6;

	// Field positions of the receiver and pin test register.
	localparam int RTS_KEY_IN_BIT   = 7;
	localparam int RTS_SUBC_OUT_BIT = 6;
	localparam int RTS_DIRECT_BIT   = 5;
	localparam int RTS_STAGE_BIT    = 4;
	localparam int RTS_ATT2_BIT     = 3;
	localparam int RTS_ATT1_BIT     = 2;
	localparam int RTS_FOLLOW_BIT   = 1;
	localparam int RTS_AGC_BIT      = 0;

	// Field positions of the decoder and I/O test register.
	localparam int RTS_RF_LEVEL_BIT = 7;
	localparam int RTS_IO_HI_BIT    = 3;
	localparam int RTS_IO_LO_BIT    = 2;
	localparam int RTS_DEC_BIT      = 1;
	localparam int RTS_FAST_CLK_BIT = 0;
	localparam logic [7:0] RTS_TEST_MODE_MASK = 8'h0e;

	// Field positions of the queue status register.
	localparam int RTS_HIGH_BIT  = 6;
	localparam int RTS_LOW_BIT   = 5;
	localparam int RTS_OVER_BIT  = 4;
	localparam int RTS_COUNT_MSB = 3;

	// Queue thresholds in bytes.
	localparam logic [3:0] RTS_HIGH_LEVEL = 4'h9;
	localparam logic [3:0] RTS_LOW_LEVEL  = 4'h3;
	localparam logic [3:0] RTS_ONE_BYTE   = 4'h1;

	// Oscillator settling time and its cycle count at 100 MHz.
	localparam int RTS_CLK_MHZ       = 100;
	localparam int RTS_OSC_SETTLE_US = 200;
	localparam int RTS_OSC_SETTLE_CYC = RTS_OSC_SETTLE_US * RTS_CLK_MHZ;

	// Link activity seen by the strength hold logic.
	typedef enum logic [1:0] {
		RTS_IDLE,
		RTS_RECEIVE,
		RTS_TRANSMIT
	} rts_phase_e;

endpackage

// [hw/rts_regs.sv]
// Strength, oscillator, test and queue status register group of the reader front end.
`timescale 1ns/10ps
module rts_regs
	import rts_pkg::*;
#(
	parameter int OSC_SETTLE_CYC = RTS_OSC_SETTLE_CYC
)
(
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	input  wire logic       chip_enable_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       rx_start_i,
	input  wire logic       rx_end_i,
	input  wire logic       tx_start_i,
	input  wire logic       tx_end_i,
	input  wire logic [2:0] first_receive_input_i,
	input  wire logic [2:0] second_receive_input_i,
	input  wire logic       swap_inputs_i,
	input  wire logic [2:0] agc_level_i,
	input  wire logic       osc_running_i,
	input  wire logic       keying_pin_i,
	input  wire logic       decoder_data_i,
	input  wire logic       rx_subcarrier_i,
	input  wire logic       coder_modulation_i,
	input  wire logic       modulation_pin_i,
	input  wire logic       stop_condition_i,
	input  wire logic [3:0] queue_bytes_i,
	input  wire logic       queue_overflow_i,
	input  wire logic       queue_flush_i,
	output logic            decoder_input_o,
	output logic            modulation_pin_o,
	output logic            modulation_pin_oe_o,
	output logic            tx_modulation_o,
	output logic            receiver_reset_o,
	output logic            second_stage_select_o,
	output logic            second_stage_attenuate_o,
	output logic            first_stage_attenuate_o,
	output logic            input_follower_test_o,
	output logic            rf_level_probe_o,
	output logic            fast_coder_clock_o,
	output logic            test_mode_o,
	output logic            queue_service_o
);

	// Either source of reset clears all state.
	logic clear;
	assign clear = srst_i || !chip_enable_i;

	// Register state.
	rts_phase_e phase_q;
	rts_phase_e phase_d;
	logic [2:0] main_peak_q;
	logic [2:0] aux_peak_q;
	logic [7:0] pin_test_q;
	logic [7:0] dec_test_q;
	logic       over_q;
	logic [31:0] osc_cnt_q;
	logic       osc_ok_q;

	// Address decode of the register port.
	logic hit_strength;
	logic hit_pin;
	logic hit_dec;
	logic hit_queue;
	assign hit_strength = reg_addr_i == RTS_SIG_STRENGTH_ADDR;
	assign hit_pin      = reg_addr_i == RTS_PIN_TEST_ADDR;
	assign hit_dec      = reg_addr_i == RTS_DEC_TEST_ADDR;
	assign hit_queue    = reg_addr_i == RTS_QUEUE_STATUS_ADDR;

	// Link phase: reception opens the measuring window, transmission ends it.
	always_comb
	begin
		phase_d = phase_q;
		case (phase_q)
			RTS_IDLE:
			begin
				if (tx_start_i)
					phase_d = RTS_TRANSMIT;
				else if (rx_start_i)
					phase_d = RTS_RECEIVE;
			end
			RTS_RECEIVE:
			begin
				if (tx_start_i)
					phase_d = RTS_TRANSMIT;
				else if (rx_end_i)
					phase_d = RTS_IDLE;
			end
			RTS_TRANSMIT:
			begin
				if (tx_end_i)
					phase_d = RTS_IDLE;
				else if (rx_start_i)
					phase_d = RTS_RECEIVE;
			end
			default:
				phase_d = RTS_IDLE;
		endcase
	end

	// Auxiliary channel follows the swap control; each code is 3 bits wide.
	logic [2:0] aux_level;
	assign aux_level = swap_inputs_i ? first_receive_input_i : second_receive_input_i;

	// Peak detect inputs: only reception raises the held values.
	logic receiving;
	logic main_higher;
	logic aux_higher;
	assign receiving   = phase_q == RTS_RECEIVE;
	assign main_higher = first_receive_input_i > main_peak_q;
	assign aux_higher  = aux_level > aux_peak_q;

	// Phase register.
	always_ff @(posedge sys_clk_i)
	begin
		if (clear)
			phase_q <= RTS_IDLE;
		else
			phase_q <= phase_d;
	end

	// Peak hold, cleared at each new transmission and held after reception ends.
	always_ff @(posedge sys_clk_i)
	begin
		if (clear || tx_start_i)
		begin
			main_peak_q <= 3'h0;
			aux_peak_q  <= 3'h0;
		end
		else if (receiving || rx_start_i)
		begin
			if (main_higher)
				main_peak_q <= first_receive_input_i;
			if (aux_higher)
				aux_peak_q <= aux_level;
		end
	end

	// Oscillator settle counter: stable flag rises after the settle time.
	always_ff @(posedge sys_clk_i)
	begin
		if (clear || !osc_running_i)
		begin
			osc_cnt_q <= 32'h0;
			osc_ok_q  <= 1'b0;
		end
		else if (osc_cnt_q >= 32'(OSC_SETTLE_CYC - 1))
			osc_ok_q <= 1'b1;
		else
			osc_cnt_q <= osc_cnt_q + 32'h1;
	end

	// Receiver and pin test register.
	always_ff @(posedge sys_clk_i)
	begin
		if (clear)
			pin_test_q <= RTS_PIN_TEST_RST;
		else if (reg_wr_i && hit_pin)
			pin_test_q <= reg_wdata_i;
	end

	// Decoder and I/O test register; a stop condition drops the test mode bits.
	logic [7:0] dec_test_stop;
	assign dec_test_stop = dec_test_q & ~RTS_TEST_MODE_MASK;
	always_ff @(posedge sys_clk_i)
	begin
		if (clear)
			dec_test_q <= RTS_DEC_TEST_RST;
		else if (reg_wr_i && hit_dec)
			dec_test_q <= reg_wdata_i;
		else if (stop_condition_i)
			dec_test_q <= dec_test_stop;
	end

	// Queue overflow is sticky until the queue is flushed; a new overflow wins.
	always_ff @(posedge sys_clk_i)
	begin
		if (clear)
			over_q <= 1'b0;
		else if (queue_overflow_i)
			over_q <= 1'b1;
		else if (queue_flush_i)
			over_q <= 1'b0;
	end

	// Queue level flags and count field.
	logic       queue_high;
	logic       queue_low;
	logic [3:0] queue_count;
	assign queue_high  = (phase_q == RTS_RECEIVE) && (queue_bytes_i >= RTS_HIGH_LEVEL);
	assign queue_low   = (phase_q == RTS_TRANSMIT) && (queue_bytes_i <= RTS_LOW_LEVEL);
	assign queue_count = (queue_bytes_i == 4'h0) ? 4'h0 : queue_bytes_i - RTS_ONE_BYTE;

	// Assembled read values of the two status registers.
	logic [2:0] main_field;
	logic [7:0] strength_word;
	logic [7:0] queue_word;
	assign main_field = pin_test_q[RTS_AGC_BIT] ? agc_level_i : main_peak_q;
	always_comb
	begin
		strength_word = 8'h00;
		strength_word[RTS_MAIN_MSB:RTS_MAIN_LSB] = main_field;
		strength_word[RTS_AUX_MSB:RTS_AUX_LSB]   = aux_peak_q;
		strength_word[RTS_OSC_BIT] = osc_ok_q;
		queue_word = 8'h00;
		queue_word[RTS_HIGH_BIT] = queue_high;
		queue_word[RTS_LOW_BIT]  = queue_low;
		queue_word[RTS_OVER_BIT] = over_q;
		queue_word[RTS_COUNT_MSB:0] = queue_count;
	end

	// Read mux; status registers decode for read only, so writes fall through.
	logic [7:0] rdata_d;
	always_comb
	begin
		if (hit_strength)
			rdata_d = strength_word;
		else if (hit_pin)
			rdata_d = pin_test_q;
		else if (hit_dec)
			rdata_d = dec_test_q;
		else if (hit_queue)
			rdata_d = queue_word;
		else
			rdata_d = 8'h00;
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge sys_clk_i)
	begin
		if (clear || !reg_rd_i)
			reg_rdata_o <= 8'h00;
		else
			reg_rdata_o <= rdata_d;
	end

	// Pin routing selected by the test registers.
	logic dec_in_d;
	logic mod_out_d;
	logic tx_mod_d;
	logic test_mode_d;
	assign dec_in_d  = pin_test_q[RTS_KEY_IN_BIT] ? keying_pin_i : decoder_data_i;
	assign mod_out_d = rx_subcarrier_i;
	assign tx_mod_d  = pin_test_q[RTS_DIRECT_BIT] ? modulation_pin_i : coder_modulation_i;
	assign test_mode_d = |(dec_test_q & RTS_TEST_MODE_MASK);

	// Registered outputs toward the analog and pin logic.
	always_ff @(posedge sys_clk_i)
	begin
		if (clear)
		begin
			decoder_input_o          <= 1'b0;
			modulation_pin_o         <= 1'b0;
			modulation_pin_oe_o      <= 1'b0;
			tx_modulation_o          <= 1'b0;
			receiver_reset_o         <= 1'b0;
			second_stage_select_o    <= 1'b0;
			second_stage_attenuate_o <= 1'b0;
			first_stage_attenuate_o  <= 1'b0;
			input_follower_test_o    <= 1'b0;
			rf_level_probe_o         <= 1'b0;
			fast_coder_clock_o       <= 1'b0;
			test_mode_o              <= 1'b0;
			queue_service_o          <= 1'b0;
		end
		else
		begin
			decoder_input_o          <= dec_in_d;
			modulation_pin_o         <= mod_out_d;
			modulation_pin_oe_o      <= pin_test_q[RTS_SUBC_OUT_BIT];
			tx_modulation_o          <= tx_mod_d;
			receiver_reset_o         <= pin_test_q[RTS_DIRECT_BIT];
			second_stage_select_o    <= pin_test_q[RTS_STAGE_BIT];
			second_stage_attenuate_o <= pin_test_q[RTS_ATT2_BIT];
			first_stage_attenuate_o  <= pin_test_q[RTS_ATT1_BIT];
			input_follower_test_o    <= pin_test_q[RTS_FOLLOW_BIT];
			rf_level_probe_o         <= dec_test_q[RTS_RF_LEVEL_BIT];
			fast_coder_clock_o       <= dec_test_q[RTS_FAST_CLK_BIT];
			test_mode_o              <= test_mode_d;
			queue_service_o          <= queue_high || queue_low;
		end
	end

endmodule

// [dv/rts_regs_chk.sv]
// Port-level assertions for the strength, test and queue status register group.
`timescale 1ns/10ps
module rts_regs_chk
	import rts_pkg::*;
#(
	parameter int OSC_SETTLE_CYC = 20
)
(
	input wire logic       sys_clk_i,
	input wire logic       srst_i,
	input wire logic       chip_enable_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       rx_start_i,
	input wire logic       tx_start_i,
	input wire logic       osc_running_i,
	input wire logic       modulation_pin_i,
	input wire logic       coder_modulation_i,
	input wire logic       stop_condition_i,
	input wire logic [3:0] queue_bytes_i,
	input wire logic       tx_modulation_o,
	input wire logic       receiver_reset_o,
	input wire logic       fast_coder_clock_o,
	input wire logic       test_mode_o,
	input wire logic       queue_service_o
);
	// Decoded strobes for the registers that the checks look at.
	wire logic rd_sig = reg_rd_i && reg_addr_i == RTS_SIG_STRENGTH_ADDR;
	wire logic rd_q   = reg_rd_i && reg_addr_i == RTS_QUEUE_STATUS_ADDR;
	wire logic wr_dec = reg_wr_i && reg_addr_i == RTS_DEC_TEST_ADDR;

	// All checks share the one clock and pause while either reset is active.
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i || !chip_enable_i);

	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read answer");
	a_sig_msb: assert property ($past(rd_sig) |-> !reg_rdata_o[7])
		else $error("strength register bit 7 set");
	a_osc_low: assert property ($past(rd_sig) && !$past(osc_running_i, 2) |-> !reg_rdata_o[6])
		else $error("oscillator flag set while oscillator stopped");
	a_tx_clear: assert property ($past(rd_sig) && $past(tx_start_i, 3) &&
		!$past(rx_start_i, 2) |-> reg_rdata_o[5:3] == 3'h0)
		else $error("aux strength not cleared by transmit start");
	a_queue_read: assert property ($past(rd_q) |-> !reg_rdata_o[7] &&
		reg_rdata_o[3:0] == ($past(queue_bytes_i) == 4'h0 ? 4'h0 : $past(queue_bytes_i) - 4'h1))
		else $error("queue status count or reserved bit wrong");
	a_service_gap: assert property ($past(queue_bytes_i) inside {[4'h4:4'h8]} |-> !queue_service_o)
		else $error("queue service raised between thresholds");
	a_test_stop: assert property (stop_condition_i && !reg_wr_i ##1 !reg_wr_i |=> !test_mode_o)
		else $error("test mode survived stop condition");
	a_fast_hold: assert property ($changed(fast_coder_clock_o) |-> $past(wr_dec, 2) ||
		$past(srst_i) || !$past(chip_enable_i))
		else $error("fast coder clock moved without a write");
	a_txmod_route: assert property (!$past(srst_i) && $past(chip_enable_i) |->
		tx_modulation_o == (receiver_reset_o ?
		$past(modulation_pin_i) : $past(coder_modulation_i)))
		else $error("transmit modulation source wrong");
endmodule

bind rts_regs rts_regs_chk #(.OSC_SETTLE_CYC(OSC_SETTLE_CYC)) u_chk (.*);

// [dv/tb_rts_regs.sv]
// Self-checking bench for the strength, test and queue status register group.
`timescale 1ns/10ps
module tb_rts_regs
	import rts_pkg::*;
;
	logic       sys_clk_i = 1'h0, srst_i = 1'h1, en = 1'h1, wr = 1'h0, rd = 1'h0;
	logic       swap = 1'h0, osc = 1'h0, subc = 1'h0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
	logic [6:0] ev = 7'h00;
	logic [3:0] bytes = 4'h0;
	logic [2:0] fin = 3'h0, sin = 3'h0, agc = 3'h0;
	logic       dec_in, mpin, mpin_oe, txm, rx_rst, st2, att2, att1, foll, rfl, fclk, tmode, qsvc;
	int         n_mismatch = 0, total_checks = 0, cyc = 0, i;
	logic [3:0] qb [7] = '{4'h0, 4'h3, 4'h4, 4'hc, 4'h8, 4'h9, 4'hc};
	logic [7:0] qe [7] = '{8'h20, 8'h22, 8'h03, 8'h0b, 8'h07, 8'h48, 8'h4b};

	// Event pulses: rx start, rx end, tx start, tx end, stop, overflow, flush.
	rts_regs #(.OSC_SETTLE_CYC(20)) uut (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .chip_enable_i(en), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.rx_start_i(ev[0]), .rx_end_i(ev[1]), .tx_start_i(ev[2]), .tx_end_i(ev[3]),
		.first_receive_input_i(fin), .second_receive_input_i(sin), .swap_inputs_i(swap),
		.agc_level_i(agc), .osc_running_i(osc), .keying_pin_i(subc), .decoder_data_i(~subc),
		.rx_subcarrier_i(subc), .coder_modulation_i(~subc), .modulation_pin_i(subc),
		.stop_condition_i(ev[4]), .queue_bytes_i(bytes), .queue_overflow_i(ev[5]),
		.queue_flush_i(ev[6]), .decoder_input_o(dec_in), .modulation_pin_o(mpin),
		.modulation_pin_oe_o(mpin_oe), .tx_modulation_o(txm), .receiver_reset_o(rx_rst),
		.second_stage_select_o(st2), .second_stage_attenuate_o(att2),
		.first_stage_attenuate_o(att1), .input_follower_test_o(foll),
		.rf_level_probe_o(rfl), .fast_coder_clock_o(fclk), .test_mode_o(tmode),
		.queue_service_o(qsvc));

	// Clock of 10 ns.
	always #5 sys_clk_i = ~sys_clk_i;

	// Toggling subcarrier and the hang limit.
	always @(posedge sys_clk_i)
	begin
		subc <= ~subc;
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch = n_mismatch + 1;
			final_report();
		end
	end

	// Compares one byte and counts the outcome.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write on the register port.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		wr <= 1'h1;
		addr <= a;
		wdata <= v;
		@(posedge sys_clk_i);
		wr <= 1'h0;
	endtask

	// One-cycle read; the answer is compared in the following cycle.
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		rd <= 1'h1;
		addr <= a;
		@(posedge sys_clk_i);
		rd <= 1'h0;
		#1 chk(rdata, exp);
	endtask

	// Raises one event input for a single cycle.
	task automatic pulse(input int b);
		@(posedge sys_clk_i);
		ev[b] <= 1'h1;
		@(posedge sys_clk_i);
		ev[b] <= 1'h0;
	endtask

	// Sets the receive level codes and the swap bit.
	task automatic set_in(input logic [2:0] f, input logic [2:0] s, input logic w);
		@(posedge sys_clk_i);
		fin <= f;
		sin <= s;
		swap <= w;
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence of tests.
	initial
	begin
		repeat (6) @(posedge sys_clk_i);
		srst_i <= 1'h0;
		osc <= 1'h1;
		rd_reg(RTS_PIN_TEST_ADDR, 8'h00);
		rd_reg(RTS_DEC_TEST_ADDR, 8'h00);
		rd_reg(8'h20, 8'h00);
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h00);
		repeat (25) @(posedge sys_clk_i);
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h40);
		$display("test 1 done");
		pulse(2);
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h40);
		set_in(3'h5, 3'h3, 1'h0);
		pulse(0);
		set_in(3'h2, 3'h3, 1'h0);
		pulse(1);
		set_in(3'h7, 3'h7, 1'h0);
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h5d);
		wr_reg(RTS_SIG_STRENGTH_ADDR, 8'hff);
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h5d);
		pulse(2);
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h40);
		set_in(3'h4, 3'h1, 1'h1);
		pulse(0);
		pulse(1);
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h64);
		wr_reg(RTS_PIN_TEST_ADDR, 8'h01);
		agc <= 3'h6;
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h66);
		@(posedge sys_clk_i);
		osc <= 1'h0;
		rd_reg(RTS_SIG_STRENGTH_ADDR, 8'h26);
		@(posedge sys_clk_i);
		osc <= 1'h1;
		$display("test 2 done");
		for (i = 1; i < 8; i++)
		begin
			d = 8'h01 << i;
			wr_reg(RTS_PIN_TEST_ADDR, d);
			rd_reg(RTS_PIN_TEST_ADDR, d);
			chk({dec_in, mpin_oe, rx_rst, st2, att2, att1, foll, txm},
				{d[7] ^ subc, d[6:1], d[5] ^ subc});
			chk({7'h0, mpin}, {7'h0, ~subc});
		end
		$display("test 3 done");
		wr_reg(RTS_DEC_TEST_ADDR, 8'h8f);
		@(posedge sys_clk_i);
		#1 chk({5'h0, rfl, fclk, tmode}, 8'h07);
		pulse(4);
		rd_reg(RTS_DEC_TEST_ADDR, 8'h81);
		chk({5'h0, rfl, fclk, tmode}, 8'h06);
		for (i = 1; i < 4; i++)
		begin
			wr_reg(RTS_DEC_TEST_ADDR, 8'h01 << i);
			rd_reg(RTS_DEC_TEST_ADDR, 8'h01 << i);
			chk({7'h0, tmode}, 8'h01);
		end
		@(posedge sys_clk_i);
		en <= 1'h0;
		@(posedge sys_clk_i);
		en <= 1'h1;
		rd_reg(RTS_DEC_TEST_ADDR, 8'h00);
		$display("test 4 done");
		pulse(2);
		for (i = 0; i < 7; i++)
		begin
			if (i == 4)
				pulse(0);
			@(posedge sys_clk_i);
			bytes <= qb[i];
			rd_reg(RTS_QUEUE_STATUS_ADDR, qe[i]);
			chk({7'h0, qsvc}, {7'h0, qe[i][6] | qe[i][5]});
		end
		pulse(5);
		wr_reg(RTS_QUEUE_STATUS_ADDR, 8'h00);
		rd_reg(RTS_QUEUE_STATUS_ADDR, 8'h5b);
		pulse(6);
		rd_reg(RTS_QUEUE_STATUS_ADDR, 8'h4b);
		pulse(3);
		$display("test 5 done");
		final_report();
	end
endmodule
